// ==== src/ace_cond.sv ====
/*
  comparator output conditioning: invert, level/edge sense for interrupt and
  converter trigger, sticky status with mask, strobe register port.
  assumes the comparator output is already synchronous to clk_i.
*/
// Decided for this implementation: the address map and the address-and-strobe port.
`timescale 1ns/100ps

// Behaviour
// - trigger sense field bits 6:5, resets level
// - irq level mode follows polarity bit 4
// - irq sense field bits 3:2, resets level
// - invert bit 1 flips output before sensing
// - bit 0 reserved, reads zero
// - trigger level mode follows polarity bit 7
// - trigger gate bit 11 passes or suppresses
module ace_cond
  import ace_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cmp_out_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic [31:0]      rdata_o,
  output logic             irq_o,
  output logic             cmp_event_o,
  output logic             adc_trigger_o
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic sense_hit(input logic [1:0] mode, input logic pol,
                                     input logic cur, input logic prev);
    logic hit;
    hit = 1'b0;
    case (mode)
      ACE_SENSE_LEVEL: hit = (cur == pol);
      ACE_SENSE_FALL:  hit = prev & ~cur;
      ACE_SENSE_RISE:  hit = ~prev & cur;
      default:         hit = prev ^ cur;
    endcase
    return hit;
  endfunction

  // one decode serves reset and writes, so the reserved bits have no storage at all
  function automatic ace_ctl_type ctl_from_word(input logic [31:0] w);
    ace_ctl_type c;
    c                        = '0;
    c.output_invert          = w[ACE_INV_BIT];
    c.irq_sense_select       = w[ACE_IRQ_SENSE_SELECT_LSB +: 2];
    c.irq_level_polarity     = w[ACE_ISLV_BIT];
    c.trigger_sense_select   = w[ACE_TRIGGER_SENSE_SELECT_LSB +: 2];
    c.trigger_level_polarity = w[ACE_TSLV_BIT];
    c.trigger_output_gate    = w[ACE_TGATE_BIT];
    return c;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  ace_bus_type bus;
  ace_ctl_type ctl_reg, ctl_next;
  logic [1:0]  stat_reg, stat_next;
  logic [1:0]  mask_reg, mask_next;
  logic        samp_reg, samp_next;
  logic        prev_reg, prev_next;
  logic        cev_reg, cev_next;
  logic        trg_reg, trg_next;
  logic        irq_reg, irq_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        cond;
  logic        irq_hit;
  logic        trg_hit;
  logic [31:0] ctl_word;

  assign bus      = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
  assign cond     = cmp_out_i ^ ctl_reg.output_invert;
  assign irq_hit  = sense_hit(ctl_reg.irq_sense_select, ctl_reg.irq_level_polarity,
                              samp_reg, prev_reg);
  assign trg_hit  = sense_hit(ctl_reg.trigger_sense_select, ctl_reg.trigger_level_polarity,
                              samp_reg, prev_reg);

  // reserved bits, bit 0 included, read as zero
  always_comb begin
    ctl_word                        = 32'h0000_0000;
    ctl_word[ACE_INV_BIT]           = ctl_reg.output_invert;
    ctl_word[ACE_IRQ_SENSE_SELECT_LSB +: 2]     = ctl_reg.irq_sense_select;
    ctl_word[ACE_ISLV_BIT]          = ctl_reg.irq_level_polarity;
    ctl_word[ACE_TRIGGER_SENSE_SELECT_LSB +: 2]     = ctl_reg.trigger_sense_select;
    ctl_word[ACE_TSLV_BIT]          = ctl_reg.trigger_level_polarity;
    ctl_word[ACE_TGATE_BIT]         = ctl_reg.trigger_output_gate;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ctl_next   = ctl_reg;
    mask_next  = mask_reg;
    rdata_next = 32'h0000_0000;
    samp_next  = cond;
    prev_next  = samp_reg;
    cev_next   = irq_hit;
    trg_next   = trg_hit & ctl_reg.trigger_output_gate;
    stat_next  = stat_reg;
    if (bus.wr && bus.addr == ACE_CTL_OFS) begin
      ctl_next = ctl_from_word(bus.wdata);
    end else if (bus.wr && bus.addr == ACE_IRQ_STAT_OFS) begin
      stat_next = stat_reg & ~bus.wdata[1:0];
    end else if (bus.wr && bus.addr == ACE_IRQ_MASK_OFS) begin
      mask_next = bus.wdata[1:0];
    end
    // set after clear so a same-cycle event is never lost
    stat_next = stat_next | {trg_hit & ctl_reg.trigger_output_gate, irq_hit};
    if (bus.rd) begin
      if (bus.addr == ACE_CTL_OFS) begin
        rdata_next = ctl_word;
      end else if (bus.addr == ACE_IRQ_STAT_OFS) begin
        rdata_next = {30'h0000_0000, stat_reg};
      end else if (bus.addr == ACE_IRQ_MASK_OFS) begin
        rdata_next = {30'h0000_0000, mask_reg};
      end else if (bus.addr == ACE_OUT_STAT_OFS) begin
        rdata_next = {30'h0000_0000, samp_reg, 1'b0};
      end else begin
        rdata_next = 32'h0000_0000;
      end
    end
    irq_next = |(stat_next & mask_next);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_reg   <= ctl_from_word(ACE_CTL_RESET);
      stat_reg  <= ACE_STAT_RESET;
      mask_reg  <= ACE_STAT_RESET;
      samp_reg  <= 1'b0;
      prev_reg  <= 1'b0;
      cev_reg   <= 1'b0;
      trg_reg   <= 1'b0;
      irq_reg   <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ctl_reg   <= ctl_next;
      stat_reg  <= stat_next;
      mask_reg  <= mask_next;
      samp_reg  <= samp_next;
      prev_reg  <= prev_next;
      cev_reg   <= cev_next;
      trg_reg   <= trg_next;
      irq_reg   <= irq_next;
      rdata_reg <= rdata_next;
    end
  end

  assign rdata_o       = rdata_reg;
  assign irq_o         = irq_reg;
  assign cmp_event_o   = cev_reg;
  assign adc_trigger_o = trg_reg;

  ////////////////////////////////////////////////////////////////////////////
  property p_trg_rise;
    @(posedge clk_i) disable iff (rst_i)
      (!rst_i && ctl_reg.trigger_sense_select == ACE_SENSE_RISE && ctl_reg.trigger_output_gate
       && !prev_reg && samp_reg && $stable(ctl_reg)) |=> adc_trigger_o;
  endproperty
  a_trg_rise: assert property (p_trg_rise) else $error("rising trigger missed");

  property p_trg_fall;
    @(posedge clk_i) disable iff (rst_i)
      (!rst_i && ctl_reg.trigger_sense_select == ACE_SENSE_FALL && ctl_reg.trigger_output_gate
       && prev_reg && !samp_reg) |=> adc_trigger_o;
  endproperty
  a_trg_fall: assert property (p_trg_fall) else $error("falling trigger missed");

  // the sampled reset in the antecedent keeps the release edge, where registers still hold reset values, out
  property p_irq_level;
    @(posedge clk_i) disable iff (rst_i)
      (!rst_i && ctl_reg.irq_sense_select == ACE_SENSE_LEVEL)
      |=> (cmp_event_o == ($past(samp_reg) == $past(ctl_reg.irq_level_polarity)));
  endproperty
  a_irq_level: assert property (p_irq_level) else $error("irq level sense wrong");

  property p_irq_fall;
    @(posedge clk_i) disable iff (rst_i)
      (ctl_reg.irq_sense_select == ACE_SENSE_FALL && !(prev_reg && !samp_reg)) |=> !cmp_event_o;
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("falling irq without edge");

  property p_irq_rise;
    @(posedge clk_i) disable iff (rst_i)
      (!rst_i && ctl_reg.irq_sense_select == ACE_SENSE_RISE && !prev_reg && samp_reg) |=> cmp_event_o;
  endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("rising irq missed");

  property p_invert;
    @(posedge clk_i) disable iff (rst_i)
      !rst_i |=> (samp_reg == ($past(cmp_out_i) ^ $past(ctl_reg.output_invert)));
  endproperty
  a_invert: assert property (p_invert) else $error("invert not applied");

  property p_rsvd;
    @(posedge clk_i) disable iff (rst_i)
      (bus.rd && bus.addr == ACE_CTL_OFS) |=> (rdata_o[0] == 1'b0 && rdata_o[31:12] == 20'h0_0000);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit read nonzero");

  property p_trg_level;
    @(posedge clk_i) disable iff (rst_i)
      (!rst_i && ctl_reg.trigger_sense_select == ACE_SENSE_LEVEL && ctl_reg.trigger_output_gate)
      |=> (adc_trigger_o == ($past(samp_reg) == $past(ctl_reg.trigger_level_polarity)));
  endproperty
  a_trg_level: assert property (p_trg_level) else $error("trigger level sense wrong");

  property p_gate;
    @(posedge clk_i) disable iff (rst_i)
      !ctl_reg.trigger_output_gate |=> !adc_trigger_o;
  endproperty
  a_gate: assert property (p_gate) else $error("trigger passed while gated");

  // no change between the two samples means no edge, so a held input gives a single pulse
  property p_edge_pulse;
    @(posedge clk_i) disable iff (rst_i)
      (!rst_i && ctl_reg.irq_sense_select == ACE_SENSE_BOTH && samp_reg == prev_reg) |=> !cmp_event_o;
  endproperty
  a_edge_pulse: assert property (p_edge_pulse) else $error("edge event not one cycle");

  property p_trg_once;
    @(posedge clk_i) disable iff (rst_i)
      (ctl_reg.trigger_sense_select != ACE_SENSE_LEVEL && samp_reg == prev_reg) |=> !adc_trigger_o;
  endproperty
  a_trg_once: assert property (p_trg_once) else $error("trigger edge event without edge");

endmodule // ace_cond

// ==== src/ace_pkg.sv ====
/*
  constants and types for the comparator event conditioning block.
  assumes a single 100 MHz system clock and a simple strobe register port.
*/
package ace_pkg;
  // register word offsets (byte addresses)
  localparam logic [7:0]  ACE_CTL_OFS        = 8'h00;
  localparam logic [7:0]  ACE_IRQ_STAT_OFS   = 8'h04;
  localparam logic [7:0]  ACE_IRQ_MASK_OFS   = 8'h08;
  localparam logic [7:0]  ACE_OUT_STAT_OFS   = 8'h0C;
  // control field positions
  localparam int          ACE_INV_BIT        = 1;
  localparam int          ACE_IRQ_SENSE_SELECT_LSB       = 2;
  localparam int          ACE_ISLV_BIT       = 4;
  localparam int          ACE_TRIGGER_SENSE_SELECT_LSB       = 5;
  localparam int          ACE_TSLV_BIT       = 7;
  localparam int          ACE_TGATE_BIT      = 11;
  localparam logic [31:0] ACE_CTL_WMASK      = 32'h0000_08FE;
  localparam logic [31:0] ACE_CTL_RESET      = 32'h0000_0000;
  // status bits: 0 comparator event, 1 trigger event
  localparam logic [1:0]  ACE_STAT_RESET     = 2'h0;
  // sense modes
  localparam logic [1:0]  ACE_SENSE_LEVEL    = 2'h0;
  localparam logic [1:0]  ACE_SENSE_FALL     = 2'h1;
  localparam logic [1:0]  ACE_SENSE_RISE     = 2'h2;
  localparam logic [1:0]  ACE_SENSE_BOTH     = 2'h3;

  typedef struct packed {
    logic        trigger_output_gate;
    logic        trigger_level_polarity;
    logic [1:0]  trigger_sense_select;
    logic        irq_level_polarity;
    logic [1:0]  irq_sense_select;
    logic        output_invert;
  } ace_ctl_type;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } ace_bus_type;
endpackage

// ==== verif/ace_adc_model.sv ====
/*
  converter-side stand-in: counts clock cycles with the trigger line high.
  assumes the trigger is registered on clk_i and one cycle per event.
*/
`timescale 1ns/100ps
module ace_adc_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic trig_i,
  output int        count_o
);
  // counting cycles, not rises, so a stretched edge pulse shows up
  always_ff @(posedge clk_i) begin
    if (rst_i) count_o <= 0;
    else if (trig_i === 1'b1) count_o <= count_o + 1;
  end
endmodule // ace_adc_model

// ==== verif/test_ace_cond.sv ====
/*
  self-checking bench: strobe-port tasks, sense mode sweep, interrupt path.
  assumes ace_cond and ace_pkg compiled first.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module test_ace_cond;
  import ace_pkg::*;
  logic        clk_i = 0, rst_i = 1, cmp_out_i = 0, wr_i = 0, rd_i = 0, irq_o, cmp_event_o, adc_trigger_o;
  logic [7:0]  addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0000_0000, rdata_o;
  int          err_count = 0, n_compared = 0, cycles = 0, ev_count = 0, trig_count, c_ev, c_tr;
  logic [31:0] ctl;
  ace_cond i_dut (.clk_i(clk_i), .rst_i(rst_i), .cmp_out_i(cmp_out_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .cmp_event_o(cmp_event_o),
    .adc_trigger_o(adc_trigger_o));
  ace_adc_model i_adc (.clk_i(clk_i), .rst_i(rst_i), .trig_i(adc_trigger_o), .count_o(trig_count));
  initial forever #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cmp_event_o === 1'b1) ev_count <= ev_count + 1;
    if (cycles == 5000) begin
      err_count++;
      print_verdict();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i); wr_i <= 1; addr_i <= a; wdata_i <= d;
    @(posedge clk_i); wr_i <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i); rd_i <= 1; addr_i <= a;
    @(posedge clk_i); rd_i <= 0;
    #1 `CHK(rdata_o, e)
  endtask
  // one pulse on the comparator: 4 cycles high, then 10 cycles low
  task automatic pulse();
    @(posedge clk_i); cmp_out_i <= 1;
    #1 c_ev = ev_count; c_tr = trig_count;
    repeat (4) @(posedge clk_i);
    cmp_out_i <= 0;
    repeat (10) @(posedge clk_i);
    #1 c_ev = ev_count - c_ev; c_tr = trig_count - c_tr;
  endtask
  // level: 4 cycles where the level matches, else 10; each edge gives one cycle
  function automatic int exp_cnt(input logic [1:0] m, input logic p, input logic v);
    if (m == ACE_SENSE_LEVEL) return (p ^ v) ? 4 : 10;
    return (m == ACE_SENSE_BOTH) ? 2 : 1;
  endfunction
  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 0;
    rd(ACE_CTL_OFS, ACE_CTL_RESET);
    rd(8'h10, 32'h0000_0000);
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      ctl = {20'h0_0000, k[0] ^ k[3], 3'h0, ~k[2], k[1:0] + 2'h1, k[2], k[1:0], k[3], 1'b0};
      wr(ACE_CTL_OFS, ctl | ~ACE_CTL_WMASK);
      rd(ACE_CTL_OFS, ctl);
      repeat (4) @(posedge clk_i);
      pulse();
      `CHK(c_ev, exp_cnt(ctl[3:2], ctl[4], ctl[1]))
      `CHK(c_tr, ctl[11] ? exp_cnt(ctl[6:5], ctl[7], ctl[1]) : 0)
    end
    $display("test sense sweep done");
    wr(ACE_CTL_OFS, 32'h0000_0008);
    repeat (4) @(posedge clk_i);
    wr(ACE_IRQ_STAT_OFS, 32'h0000_0003);
    pulse();
    rd(ACE_IRQ_STAT_OFS, 32'h0000_0001);
    `CHK(irq_o, 1'b0)
    wr(ACE_IRQ_MASK_OFS, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    #1 `CHK(irq_o, 1'b1)
    wr(ACE_IRQ_STAT_OFS, 32'h0000_0001);
    repeat (2) @(posedge clk_i);
    #1 `CHK(irq_o, 1'b0)
    rd(ACE_IRQ_STAT_OFS, 32'h0000_0000);
    $display("test interrupt done");
    wr(ACE_CTL_OFS, 32'h0000_000A);
    rd(ACE_OUT_STAT_OFS, 32'h0000_0002);
    @(posedge clk_i);
    rst_i <= 1;
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    rd(ACE_CTL_OFS, ACE_CTL_RESET);
    rd(ACE_IRQ_MASK_OFS, 32'h0000_0000);
    `CHK(irq_o, 1'b0)
    $display("test mid reset done");
    print_verdict();
  end
endmodule // test_ace_cond
